// >>> design/ebp_pkg.sv
/*
 * constants and carrier types for the eight-bit port with analog select.
 * assumes a register port with one-cycle read latency and synchronous pins.
 */
package ebp_pkg;
	// =====================================
	// register map
	localparam logic [15:0] EBP_ADDR_DATA_LATCH    = 16'h0003;
	localparam logic [15:0] EBP_ADDR_DIRECTION     = 16'h0006;
	localparam logic [15:0] EBP_ADDR_INPUT_CONTROL = 16'h0007;
	// =====================================
	// reset values
	localparam logic [7:0]  EBP_RST_DATA_LATCH     = 8'h00;
	localparam logic [7:0]  EBP_RST_DIRECTION      = 8'h00;
	localparam logic [7:0]  EBP_RST_INPUT_CONTROL  = 8'hFF;
	// =====================================
	// alternate function bit positions
	localparam int          EBP_WAKEUP_LSB         = 3;
	localparam int          EBP_IRQ_ZERO_BIT       = 1;
	localparam int          EBP_EMERGENCY_BIT      = 0;
	// =====================================
	// register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} ebp_req_t;
	// =====================================
	// pin group, output enable low while driving
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
	} ebp_pin_t;
endpackage : ebp_pkg

// >>> design/ebp_port.sv
/*
 * eight-bit port: latch, direction and input control registers, pin drive,
 * alternate function routing. assumes software follows the setup order.
 */
`timescale 1ns/1ps
module ebp_port (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// register port
	input  wire ebp_pkg::ebp_req_t req_i,
	output logic [7:0]         rdata_o,
	// pins
	input  wire logic [7:0]    pin_i,
	output ebp_pkg::ebp_pin_t  pin_o,
	// alternate functions
	output logic [7:0]         analog_enable_o,
	output logic [3:0]         wakeup_key_o,
	output logic               external_irq_zero_o,
	output logic               emergency_halt_input_o
);
	logic [7:0] port_three_data_latch;
	logic [7:0] port_three_direction;
	logic [7:0] port_three_input_control;
	logic [7:0] digital_in;
	logic [7:0] next_read;

	// =====================================
	// per-bit read selection
	function automatic logic [7:0] ebp_read_sel(input logic [7:0] dir,
		input logic [7:0] ictl, input logic [7:0] latch, input logic [7:0] pin);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (dir[i]) begin
				v[i] = latch[i];
			end else if (ictl[i]) begin
				v[i] = pin[i];
			end else begin
				v[i] = 1'b0;
			end
		end
		return v;
	endfunction : ebp_read_sel

	// =====================================
	// digital input gating: analog pins never toggle the logic
	assign digital_in = pin_i & port_three_input_control;

	// =====================================
	// registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_three_data_latch <= ebp_pkg::EBP_RST_DATA_LATCH;
		end else if (req_i.wr && req_i.addr == ebp_pkg::EBP_ADDR_DATA_LATCH) begin
			// read-modify-write happens in software, so whatever it wrote lands
			port_three_data_latch <= req_i.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_three_direction <= ebp_pkg::EBP_RST_DIRECTION;
		end else if (req_i.wr && req_i.addr == ebp_pkg::EBP_ADDR_DIRECTION) begin
			port_three_direction <= req_i.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_three_input_control <= ebp_pkg::EBP_RST_INPUT_CONTROL;
		end else if (req_i.wr && req_i.addr == ebp_pkg::EBP_ADDR_INPUT_CONTROL) begin
			port_three_input_control <= req_i.wdata;
		end
	end

	// =====================================
	// read data, valid the cycle after the strobe only
	always_comb begin
		next_read = 8'h00;
		if (req_i.addr == ebp_pkg::EBP_ADDR_DATA_LATCH) begin
			next_read = ebp_read_sel(port_three_direction, port_three_input_control,
				port_three_data_latch, pin_i);
		end else if (req_i.addr == ebp_pkg::EBP_ADDR_DIRECTION) begin
			next_read = port_three_direction;
		end else if (req_i.addr == ebp_pkg::EBP_ADDR_INPUT_CONTROL) begin
			next_read = port_three_input_control;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (req_i.rd) begin
			rdata_o <= next_read;
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// =====================================
	// pin drive, registered so outputs come from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_o.out  <= 8'h00;
			pin_o.oe_n <= 8'hFF;
		end else begin
			pin_o.out  <= port_three_data_latch;
			pin_o.oe_n <= ~port_three_direction;
		end
	end

	// =====================================
	// alternate function routing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			analog_enable_o        <= 8'h00;
			wakeup_key_o           <= 4'h0;
			external_irq_zero_o    <= 1'b0;
			emergency_halt_input_o <= 1'b0;
		end else begin
			// analog channel live only when direction and input control are clear
			analog_enable_o        <= ~(port_three_direction | port_three_input_control);
			wakeup_key_o           <= digital_in[ebp_pkg::EBP_WAKEUP_LSB +: 4];
			external_irq_zero_o    <= digital_in[ebp_pkg::EBP_IRQ_ZERO_BIT];
			emergency_halt_input_o <= digital_in[ebp_pkg::EBP_EMERGENCY_BIT];
		end
	end
endmodule : ebp_port

// >>> testbench/ebp_chk.sv
/* port checker: pin drive, read data, gating.
   bound to ebp_port, sees only its ports. */
`timescale 1ns/1ps
module ebp_chk (
	// watched ports
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire ebp_pkg::ebp_req_t req_i,
	input wire logic [7:0]        rdata_o,
	input wire logic [7:0]        pin_i,
	input wire ebp_pkg::ebp_pin_t pin_o,
	input wire logic [7:0]        analog_enable_o,
	input wire logic [3:0]        wakeup_key_o,
	input wire logic              external_irq_zero_o,
	input wire logic              emergency_halt_input_o
);
	wire logic wd = req_i.wr && req_i.addr == 16'h0006;
	wire logic wl = req_i.wr && req_i.addr == 16'h0003;
	wire logic r3 = req_i.rd && req_i.addr == 16'h0003;
	// ==========
	// properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_rst; $fell(rst_i) |-> pin_o.oe_n == 8'hFF && !pin_o.out && !analog_enable_o;
	endproperty
	property p_dir; wd ##1 !wd |=> pin_o.oe_n == ~$past(req_i.wdata, 2); endproperty
	property p_lat; wl ##1 !wl |=> pin_o.out == $past(req_i.wdata, 2); endproperty
	property p_rd; !$past(req_i.wr) && r3 |=> (rdata_o & ~$past(pin_o.oe_n)) ==
		($past(pin_o.out) & ~$past(pin_o.oe_n)); endproperty
	property p_rdz; !$past(req_i.wr) && r3 |=> !(rdata_o & $past(analog_enable_o)); endproperty
	property p_idle; !req_i.rd |=> rdata_o == 8'h00; endproperty
	property p_gate; !(wakeup_key_o & analog_enable_o[6:3]) && !(analog_enable_o & ~pin_o.oe_n);
	endproperty
	// outputs lag one edge, so the edge after reset is skipped
	property p_alt; !$past(rst_i) && pin_o.oe_n[1] && !analog_enable_o[1] |->
		external_irq_zero_o == $past(pin_i[1]); endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	a_dir: assert property (p_dir) else $error("direction drive");
	a_lat: assert property (p_lat) else $error("latch write");
	a_rd: assert property (p_rd) else $error("latch read");
	a_rdz: assert property (p_rdz) else $error("analog read");
	a_idle: assert property (p_idle) else $error("idle read data");
	a_gate: assert property (p_gate) else $error("input gating");
	a_alt: assert property (p_alt) else $error("irq routing");
	c_rd: cover property (r3 ##1 rdata_o != 8'h00);
	c_an: cover property (analog_enable_o != 8'h00);
	c_out: cover property (pin_o.oe_n != 8'hFF);
endmodule : ebp_chk

// >>> testbench/ebp_pins.sv
/* pin model: outside drivers meet the port drive.
   assumes ext_i is the level of released pins. */
`timescale 1ns/1ps
module ebp_pins (
	// port drive and outside level
	input  wire ebp_pkg::ebp_pin_t pin_i,
	input  wire logic [7:0]        ext_i,
	// resolved level
	output logic [7:0]             level_o
);
	assign level_o = (pin_i.out & ~pin_i.oe_n) | (ext_i & pin_i.oe_n);
endmodule : ebp_pins

// >>> testbench/tb.sv
/* top bench: register tasks, pin model, checks.
   assumes one-cycle read data. */
`timescale 1ns/1ps
module tb;
	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	ebp_pkg::ebp_req_t req = '0;
	ebp_pkg::ebp_pin_t po;
	logic [7:0]        rdata, ae, lvl;
	logic [7:0]        ext = 8'hA5;
	logic [3:0]        wk;
	logic              irq, emergency_halt_input;
	int                miscompares = 0;
	int                total_checks = 0;
	initial forever #5 clk_i = ~clk_i;
	ebp_port u_dut (.clk_i, .rst_i, .req_i(req), .rdata_o(rdata), .pin_i(lvl), .pin_o(po),
		.analog_enable_o(ae), .wakeup_key_o(wk), .external_irq_zero_o(irq),
		.emergency_halt_input_o(emergency_halt_input));
	ebp_pins u_pins (.pin_i(po), .ext_i(ext), .level_o(lvl));
	task chk(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %0t saw %h want %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i) req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i) req <= '0;
	endtask : wr
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_i) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_i) req <= '0;
		#1 chk(rdata, e);
	endtask : rd
	task settle;
		repeat (3) @(posedge clk_i);
		#1;
	endtask : settle
	task test_done;
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(16'h0006, 8'h00);
		rd(16'h0007, 8'hFF);
		chk(po.oe_n, 8'hFF);
		rd(16'h0003, 8'hA5);
		rd(16'h0010, 8'h00);
		wr(16'h0003, 8'h3C);
		rd(16'h0003, 8'hA5);
		wr(16'h0006, 8'hF0);
		rd(16'h0003, 8'h35);
		settle;
		chk(po.out, 8'h3C);
		chk(po.oe_n, 8'h0F);
		wr(16'h0007, 8'hF3);
		rd(16'h0003, 8'h31);
		settle;
		chk(ae, 8'h0C);
		chk({4'h0, wk}, 8'h06);
		chk({6'h00, irq, emergency_halt_input}, 8'h01);
		wr(16'h0006, 8'h00);
		wr(16'h0007, 8'hFF);
		rd(16'h0003, 8'hA5);
		wr(16'h0003, 8'hA7);
		wr(16'h0006, 8'hFF);
		rd(16'h0003, 8'hA7);
		test_done;
	end
endmodule : tb
bind ebp_port ebp_chk u_chk (.clk_i, .rst_i, .req_i, .rdata_o, .pin_i, .pin_o,
	.analog_enable_o, .wakeup_key_o, .external_irq_zero_o, .emergency_halt_input_o);
